//--- msdseq_consts.svh
// constants of the module shutdown sequencer: timing figures and reset values
// assumes a single core clock whose rate is given here in kHz
`ifndef MSDSEQ_CONSTS_SVH
`define MSDSEQ_CONSTS_SVH

// ----------------------------------------
// clock and counter sizing
// ----------------------------------------
`define MSD_CLK_KHZ 25000
`define MSD_CNT_W 27

// ----------------------------------------
// press and shutdown times in milliseconds
// ----------------------------------------
`define MSD_KEY_ON_MS 1000
`define MSD_KEY_OFF_MS 2500
`define MSD_KILL_MS 200
`define MSD_FAST_MS 30

// ----------------------------------------
// cycle counts derived from the times
// ----------------------------------------
`define MSD_KEY_ON_CNT (`MSD_KEY_ON_MS * `MSD_CLK_KHZ)
`define MSD_KEY_OFF_CNT (`MSD_KEY_OFF_MS * `MSD_CLK_KHZ)
`define MSD_KILL_CNT (`MSD_KILL_MS * `MSD_CLK_KHZ)
`define MSD_FAST_CNT (`MSD_FAST_MS * `MSD_CLK_KHZ)

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSD_PIN_IDLE 1'b1
`define MSD_CNT_RST 27'h0000000

`endif

//--- msdseq_pkg.sv
// types shared by the module shutdown sequencer and its pin filter
// assumes msdseq_consts.svh is on the include path
`include "msdseq_consts.svh"

package msdseq_pkg;

	typedef logic [`MSD_CNT_W-1:0] msdseq_cnt_t;

	typedef enum logic [2:0]
	{
		ST_OFF,
		ST_BOOT,
		ST_ON,
		ST_FINAL,
		ST_FAST
	} msdseq_state_e;

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} msdseq_sync_s;

	typedef struct packed
	{
		msdseq_state_e st;
		msdseq_cnt_t key_cnt;
		msdseq_cnt_t kill_cnt;
		msdseq_cnt_t fast_cnt;
		logic key_armed;
		logic trig_prev;
		logic pmon;
		logic aux;
	} msdseq_core_s;

endpackage

//--- msdseq_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous single-bit pin and the core clock
`timescale 1ns/1ps
`default_nettype none
`include "msdseq_consts.svh"

module msdseq_pin_sync
	import msdseq_pkg::*;
#(
	parameter logic RST_VAL = `MSD_PIN_IDLE
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic q_o
);

	msdseq_sync_s sync_r;
	msdseq_sync_s sync_nxt;

	// s1 feeds only s2; the output moves once s2 and s3 agree
	always_comb
	begin
		sync_nxt = sync_r;
		sync_nxt.s1 = pin_i;
		sync_nxt.s2 = sync_r.s1;
		sync_nxt.s3 = sync_r.s2;
		if (sync_r.s2 == sync_r.s3)
		begin
			sync_nxt.q = sync_r.s3;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
		end
		else
		begin
			sync_r <= sync_nxt;
		end
	end

	assign q_o = sync_r.q;

endmodule

`default_nettype wire

//--- msdseq_top.sv
// module shutdown sequencer: power key, hard kill and fast shutdown handling
// assumes firmware supplies command pulses and done levels on the core clock
//
// Functional notes
// - A power key hold longer than 2.5 s moves the device into finalization and later drops the power monitor.
// - A software shutdown command starts finalization and the power monitor drops when it ends.
// - The power monitor is low only while the device is off or still booting (ST_OFF or ST_BOOT).
// - A falling edge on the enabled trigger pin starts fast shutdown and the device is off within 30 ms of entering fast shutdown.
// - The auxiliary rail output goes low once the device has turned off.
// - A fast shutdown software command starts fast shutdown without any pin edge.
// - The power monitor rises once pad initialization has finished during power-up.
`timescale 1ns/1ps
`default_nettype none
`include "msdseq_consts.svh"

module msdseq_top
	import msdseq_pkg::*;
#(
	parameter int unsigned KEY_ON_CNT = `MSD_KEY_ON_CNT,
	parameter int unsigned KEY_OFF_CNT = `MSD_KEY_OFF_CNT,
	parameter int unsigned KILL_CNT = `MSD_KILL_CNT,
	parameter int unsigned FAST_CNT = `MSD_FAST_CNT
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic power_key_n_i,
	input wire logic hard_kill_n_i,
	input wire logic fast_trig_pin_i,
	input wire logic fast_trig_en_i,
	input wire logic shutdown_cmd_i,
	input wire logic fast_shutdown_cmd_i,
	input wire logic finalize_done_i,
	input wire logic fast_done_i,
	input wire logic pads_init_done_i,
	output logic power_monitor_o,
	output logic aux_rail_out_o,
	output logic finalizing_o,
	output logic fast_active_o
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	localparam longint unsigned CNT_LIM = 64'h1 << `MSD_CNT_W;

	if (KEY_ON_CNT < 2 || KEY_OFF_CNT < 2 || KILL_CNT < 2 || FAST_CNT < 2)
	begin : g_chk_min
		$error("sequencer counts must be at least two cycles");
	end
	if (KEY_ON_CNT >= CNT_LIM || KEY_OFF_CNT >= CNT_LIM || KILL_CNT >= CNT_LIM ||
		FAST_CNT >= CNT_LIM)
	begin : g_chk_max
		$error("sequencer count exceeds counter width");
	end

	localparam msdseq_cnt_t KEY_ON_END = msdseq_cnt_t'(KEY_ON_CNT - 1);
	localparam msdseq_cnt_t KEY_OFF_END = msdseq_cnt_t'(KEY_OFF_CNT - 1);
	localparam msdseq_cnt_t KILL_END = msdseq_cnt_t'(KILL_CNT - 1);
	localparam msdseq_cnt_t FAST_END = msdseq_cnt_t'(FAST_CNT - 1);

	// ----------------------------------------
	// pin filters
	// ----------------------------------------
	logic key_n;
	logic kill_n;
	logic trig;

	msdseq_pin_sync u_key_sync
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(power_key_n_i),
		.q_o(key_n)
	);

	msdseq_pin_sync u_kill_sync
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(hard_kill_n_i),
		.q_o(kill_n)
	);

	msdseq_pin_sync u_trig_sync
	(
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(fast_trig_pin_i),
		.q_o(trig)
	);

	// ----------------------------------------
	// state and next-state logic
	// ----------------------------------------
	msdseq_core_s core_r;
	msdseq_core_s core_nxt;

	logic key_on_fire;
	logic key_off_fire;
	logic kill_fire;
	logic fast_fire;
	logic live;

	// saturating count while a line is held, cleared on release
	function automatic msdseq_cnt_t hold_cnt(input logic held, input msdseq_cnt_t cnt);
		if (!held)
		begin
			return '0;
		end
		if (&cnt)
		begin
			return cnt;
		end
		return cnt + msdseq_cnt_t'(1);
	endfunction

	assign live = (core_r.st == ST_ON) || (core_r.st == ST_FINAL);
	assign kill_fire = !kill_n && (core_r.kill_cnt == KILL_END) && (core_r.st != ST_OFF);
	// falling edge seen only on the filtered level, never on a raw flop
	assign fast_fire = live && ((fast_trig_en_i && core_r.trig_prev && !trig) ||
		fast_shutdown_cmd_i);
	assign key_on_fire = (core_r.st == ST_OFF) && !key_n && (core_r.key_cnt == KEY_ON_END);
	// the key must be released after power-on before a hold can count toward shutdown
	assign key_off_fire = (core_r.st == ST_ON) && core_r.key_armed && !key_n &&
		(core_r.key_cnt == KEY_OFF_END);

	always_comb
	begin
		core_nxt = core_r;
		core_nxt.key_cnt = hold_cnt(!key_n, core_r.key_cnt);
		core_nxt.kill_cnt = hold_cnt(!kill_n, core_r.kill_cnt);
		core_nxt.trig_prev = trig;
		if (key_n)
		begin
			core_nxt.key_armed = 1'b1;
		end
		// hard kill overrides everything, then fast shutdown, then graceful paths
		if (kill_fire)
		begin
			core_nxt.st = ST_OFF;
			core_nxt.pmon = 1'b0;
			core_nxt.aux = 1'b0;
		end
		else if (fast_fire)
		begin
			core_nxt.st = ST_FAST;
			core_nxt.fast_cnt = '0;
		end
		else
		begin
			case (core_r.st)
				ST_OFF:
				begin
					if (key_on_fire)
					begin
						core_nxt.st = ST_BOOT;
						core_nxt.aux = 1'b1;
						core_nxt.key_armed = 1'b0;
					end
				end
				ST_BOOT:
				begin
					if (pads_init_done_i)
					begin
						core_nxt.st = ST_ON;
						core_nxt.pmon = 1'b1;
					end
				end
				ST_ON:
				begin
					if (shutdown_cmd_i || key_off_fire)
					begin
						core_nxt.st = ST_FINAL;
					end
				end
				ST_FINAL:
				begin
					if (finalize_done_i)
					begin
						core_nxt.st = ST_OFF;
						core_nxt.pmon = 1'b0;
						core_nxt.aux = 1'b0;
					end
				end
				ST_FAST:
				begin
					core_nxt.fast_cnt = core_r.fast_cnt + msdseq_cnt_t'(1);
					// the timeout caps the fast path even if firmware never reports done
					if (fast_done_i || core_r.fast_cnt == FAST_END)
					begin
						core_nxt.st = ST_OFF;
						core_nxt.pmon = 1'b0;
						core_nxt.aux = 1'b0;
					end
				end
				default:
				begin
					core_nxt.st = ST_OFF;
					core_nxt.pmon = 1'b0;
					core_nxt.aux = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			core_r <= '{st: ST_OFF, key_cnt: `MSD_CNT_RST, kill_cnt: `MSD_CNT_RST,
				fast_cnt: `MSD_CNT_RST, key_armed: 1'b0, trig_prev: `MSD_PIN_IDLE,
				pmon: 1'b0, aux: 1'b0};
		end
		else
		begin
			core_r <= core_nxt;
		end
	end

	assign power_monitor_o = core_r.pmon;
	assign aux_rail_out_o = core_r.aux;
	assign finalizing_o = (core_r.st == ST_FINAL);
	assign fast_active_o = (core_r.st == ST_FAST);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_quiet;
		!kill_fire && !fast_fire;
	endsequence

	sequence s_final_ends;
		core_r.st == ST_FINAL && finalize_done_i ##0 s_quiet;
	endsequence

	key_off_final_a: assert property (key_off_fire ##0 s_quiet |=> core_r.st == ST_FINAL)
		else $error("key hold did not start finalization");

	cmd_final_a: assert property (core_r.st == ST_ON && shutdown_cmd_i ##0 s_quiet
		|=> core_r.st == ST_FINAL && power_monitor_o)
		else $error("shutdown command did not start finalization");

	final_pmon_drop_a: assert property (s_final_ends |=> !power_monitor_o && core_r.st == ST_OFF)
		else $error("power monitor still high after finalization");

	pmon_low_off_a: assert property (!power_monitor_o |-> core_r.st == ST_OFF ||
		core_r.st == ST_BOOT)
		else $error("power monitor low while device running");

	fast_edge_start_a: assert property (live && fast_trig_en_i && $fell(trig) && !kill_fire
		|=> core_r.st == ST_FAST)
		else $error("trigger edge did not start fast shutdown");

	fast_time_cap_a: assert property (core_r.st == ST_FAST |-> core_r.fast_cnt <= FAST_END)
		else $error("fast shutdown exceeded its time limit");

	fast_cmd_start_a: assert property (live && fast_shutdown_cmd_i && !kill_fire
		|=> core_r.st == ST_FAST ##1 core_r.fast_cnt == msdseq_cnt_t'(1) ||
		core_r.st == ST_OFF)
		else $error("fast command did not start fast shutdown");

	aux_off_low_a: assert property ($fell(aux_rail_out_o) |-> core_r.st == ST_OFF &&
		!power_monitor_o)
		else $error("aux rail dropped without turning off");

	pads_pmon_rise_a: assert property (core_r.st == ST_BOOT && pads_init_done_i && !kill_fire
		|=> power_monitor_o && aux_rail_out_o)
		else $error("power monitor did not rise after pad init");

endmodule

`default_nettype wire

//--- msdseq_note_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- msdseq_host.sv
// host controller model: open-collector power key and hard kill drivers
// assumes the bench pulses a go input for one cycle with the minimum hold
`timescale 1ns/1ps
`default_nettype none

module msdseq_host
	import msdseq_pkg::*;
#(
	parameter int MARGIN = 4
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic key_go_i,
	input wire logic kill_go_i,
	input wire logic [7:0] hold_i,
	output logic power_key_n_o,
	output logic hard_kill_n_o
);
	// ----------------------------------------
	// press timer
	// ----------------------------------------
	logic [8:0] cnt_r;
	logic key_r;
	logic kill_r;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_r <= 9'h000;
			key_r <= 1'h0;
			kill_r <= 1'h0;
		end
		else if (key_go_i || kill_go_i)
		begin
			// extra cycles beyond the minimum hold before letting go
			cnt_r <= {1'h0, hold_i} + 9'(MARGIN);
			key_r <= key_go_i;
			kill_r <= kill_go_i;
		end
		else if (cnt_r != 9'h000)
			cnt_r <= cnt_r - 9'h001;
		else
		begin
			key_r <= 1'h0;
			kill_r <= 1'h0;
		end
	end

	// ----------------------------------------
	// pins: driven low while pressed, otherwise driven high to stand in for the pulled-up level
	// ----------------------------------------
	assign power_key_n_o = key_r ? 1'h0 : 1'h1;
	assign hard_kill_n_o = kill_r ? 1'h0 : 1'h1;
endmodule

`default_nettype wire

//--- msdseq_tb.sv
// bench for the module shutdown sequencer with a host model on its pins
// assumes shortened press counts; one core clock at 25 MHz
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import msdseq_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int K_ON = 20;
	localparam int K_OFF = 50;
	localparam int KILL = 10;
	localparam int FAST = 30;
	logic core_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic key_go = 1'h0;
	logic kill_go = 1'h0;
	logic [7:0] hold = 8'h00;
	logic trig = 1'h1;
	logic trig_en = 1'h0;
	logic sd_cmd = 1'h0;
	logic fast_cmd = 1'h0;
	logic fin_done = 1'h0;
	logic fast_done = 1'h0;
	logic pads = 1'h0;
	wire logic key_n;
	wire logic kill_n;
	wire logic pmon;
	wire logic aux;
	wire logic fin;
	wire logic fast;
	wire logic [3:0] outs;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	assign outs = {pmon, aux, fin, fast};

	always #20 core_clk_i = ~core_clk_i;

	msdseq_host u_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .key_go_i(key_go),
		.kill_go_i(kill_go), .hold_i(hold), .power_key_n_o(key_n), .hard_kill_n_o(kill_n));

	msdseq_top #(.KEY_ON_CNT(K_ON), .KEY_OFF_CNT(K_OFF), .KILL_CNT(KILL), .FAST_CNT(FAST)) DUT (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .power_key_n_i(key_n),
		.hard_kill_n_i(kill_n), .fast_trig_pin_i(trig), .fast_trig_en_i(trig_en),
		.shutdown_cmd_i(sd_cmd), .fast_shutdown_cmd_i(fast_cmd), .finalize_done_i(fin_done),
		.fast_done_i(fast_done), .pads_init_done_i(pads), .power_monitor_o(pmon),
		.aux_rail_out_o(aux), .finalizing_o(fin), .fast_active_o(fast));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task wait_bit(input int idx, input logic lvl, input int lim, output int n);
		n = 0;
		while (outs[idx] !== lvl && n < lim)
		begin
			tick(1);
			n++;
		end
	endtask

	task press(input logic kill, input int len);
		key_go = !kill;
		kill_go = kill;
		hold = 8'(len);
		tick(1);
		key_go = 1'h0;
		kill_go = 1'h0;
		tick(len + 8);
	endtask

	task pulse_sd;
		sd_cmd = 1'h1;
		tick(1);
		sd_cmd = 1'h0;
	endtask

	task power_on;
		int n;
		press(1'h0, K_ON);
		check("aux in boot", aux, 1'h1);
		check("pmon in boot", pmon, 1'h0);
		pads = 1'h1;
		wait_bit(3, 1'h1, 4, n);
		check("pmon after pads", pmon, 1'h1);
		pads = 1'h0;
		tick(4);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		check("outs after reset", outs, 4'h0);
		press(1'h0, K_ON - 8);
		check("short key press", outs, 4'h0);
		$display("test reset done");
	endtask

	task t_graceful;
		power_on();
		pulse_sd();
		check("finalizing", fin, 1'h1);
		tick(20);
		check("pmon in final", pmon, 1'h1);
		fin_done = 1'h1;
		tick(1);
		fin_done = 1'h0;
		check("outs after final", outs, 4'h0);
		$display("test graceful done");
	endtask

	task t_key_off;
		power_on();
		press(1'h0, K_OFF - 20);
		check("short off press", fin, 1'h0);
		press(1'h0, K_OFF);
		check("key finalizing", {fin, pmon}, 4'h3);
		fin_done = 1'h1;
		tick(1);
		fin_done = 1'h0;
		check("outs after key off", outs, 4'h0);
		$display("test key off done");
	endtask

	task t_fast_pin;
		int n1;
		int n2;
		power_on();
		trig = 1'h0;
		tick(8);
		check("trig disabled", fast, 1'h0);
		trig = 1'h1;
		trig_en = 1'h1;
		tick(8);
		trig = 1'h0;
		wait_bit(0, 1'h1, 8, n1);
		check("fast by pin", fast, 1'h1);
		wait_bit(3, 1'h0, FAST + 4, n2);
		check("off within limit", n1 + n2 <= FAST + 5, 1'h1);
		check("aux after fast", aux, 1'h0);
		// trigger left low so no high level faces a powered-off pin
		trig_en = 1'h0;
		$display("test fast pin done");
	endtask

	task t_fast_cmd;
		power_on();
		pulse_sd();
		fast_cmd = 1'h1;
		tick(1);
		fast_cmd = 1'h0;
		check("fast over final", {fin, fast}, 4'h1);
		tick(3);
		fast_done = 1'h1;
		tick(1);
		fast_done = 1'h0;
		check("outs after fast cmd", outs, 4'h0);
		$display("test fast cmd done");
	endtask

	task t_kill;
		power_on();
		pulse_sd();
		press(1'h1, KILL);
		check("outs after kill", outs, 4'h0);
		$display("test kill done");
	endtask

	task wrap_up;
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			wrap_up();
		end
	end

	initial
	begin
		tick(5);
		rst_n_i = 1'h1;
		tick(4);
		t_reset();
		t_graceful();
		t_key_off();
		t_fast_cmd();
		t_kill();
		t_fast_pin();
		wrap_up();
	end
endmodule

`default_nettype wire
